/* pfs_checker.sv */
module pfs_checker #(parameter W = 32, parameter OW = 64, parameter LW = 16) (
   // stimulus
   input logic i_core_clk, i_sys_rst, i_clr, i_tx_done, i_cpu_rx, i_cpu_tx,
   input logic [LW-1:0] i_tx_len, i_cpu_rx_len, i_cpu_tx_len,
   // results
   input logic [OW-1:0] o_tx_octets, o_cpu_rx_octets, o_cpu_tx_octets,
   input logic [W-1:0] o_tx_err_total, o_tx_disc_total, o_secs_since_clr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   // ==========================================
   // properties
   AST_CLR_OCT: assert property (i_clr |=> o_tx_octets == 0 && o_cpu_tx_octets == 0)
      else $error("octets kept over clear");
   AST_CLR_SEC: assert property (i_clr |=> o_secs_since_clr == 0)
      else $error("seconds kept over clear");
   AST_TX_OCT: assert property (i_tx_done && !i_clr |=>
      o_tx_octets == $past(o_tx_octets) + $past(i_tx_len)) else $error("tx octets");
   AST_TX_HOLD: assert property (!i_tx_done && !i_clr |=> $stable(o_tx_octets))
      else $error("tx octets moved");
   AST_CPU_RX: assert property (i_cpu_rx && !i_clr |=>
      o_cpu_rx_octets == $past(o_cpu_rx_octets) + $past(i_cpu_rx_len)) else $error("cpu rx");
   AST_CPU_TX: assert property (i_cpu_tx && !i_clr |=>
      o_cpu_tx_octets == $past(o_cpu_tx_octets) + $past(i_cpu_tx_len) + 16'h14)
      else $error("cpu tx");
   AST_TOT_EQ: assert property (o_tx_err_total == o_tx_disc_total)
      else $error("totals differ");
   AST_TOT_HOLD: assert property (!i_tx_done && !i_clr ##1 !i_clr |=> $stable(o_tx_err_total))
      else $error("total moved");
   cover property (i_tx_done && i_clr);
   cover property (i_cpu_tx ##1 i_cpu_tx);
   cover property (i_clr ##1 i_tx_done);
endmodule // pfs_checker

/* pfs_defs.vh */
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH
// ==========================================
// counter indices
`define PFS_C_PAUSE 5'd0
`define PFS_C_H64 5'd1
`define PFS_C_H127 5'd2
`define PFS_C_H255 5'd3
`define PFS_C_H511 5'd4
`define PFS_C_H1023 5'd5
`define PFS_C_H1518 5'd6
`define PFS_C_H1522 5'd7
`define PFS_C_FCS 5'd8
`define PFS_C_OVERSZ 5'd9
`define PFS_C_UNDRUN 5'd10
`define PFS_C_SCOL 5'd11
`define PFS_C_MCOL 5'd12
`define PFS_C_XCOL 5'd13
`define PFS_C_EGRMEM 5'd14
`define PFS_C_INGMEM 5'd15
`define PFS_C_FTYPE 5'd16
`define PFS_C_LOCAL 5'd17
`define PFS_C_VLANV 5'd18
`define PFS_C_MTREE 5'd19
`define PFS_C_RSVD 5'd20
`define PFS_C_CFI 5'd21
`define PFS_C_NODESC 5'd22
`define PFS_C_UCAST 5'd23
`define PFS_C_MCAST 5'd24
`define PFS_C_BCAST 5'd25
`define PFS_C_EAPRX 5'd26
`define PFS_C_EAPTX 5'd27
`define PFS_NUM_EVT 28
// length thresholds, octets including checksum
`define PFS_LEN_MIN 16'h0040
`define PFS_LEN_127 16'h007f
`define PFS_LEN_255 16'h00ff
`define PFS_LEN_511 16'h01ff
`define PFS_LEN_1023 16'h03ff
`define PFS_LEN_1518 16'h05ee
`define PFS_LEN_1522 16'h05f2
// one-second tick for the time-since-cleared reference
`define PFS_CLK_HZ 250000000
`define PFS_SEC_CYC (`PFS_CLK_HZ)
`endif

/* pfs_evt_cnt.v */
`include "pfs_defs.vh"
// ==========================================
// bank of event counters, each wraps at its top value
module pfs_evt_cnt #(
   parameter N = 28,
   parameter W = 32
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_clr,
   // events
   input wire [N-1:0] i_inc,
   // counts
   output wire [N*W-1:0] o_cnt
);
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_cnt
         reg [W-1:0] cnt_r;
         always @(posedge i_core_clk) begin
            if (i_sys_rst || i_clr) begin
               cnt_r <= {W{1'b0}};
            end else if (i_inc[g]) begin
               cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
         end
         assign o_cnt[g*W +: W] = cnt_r;
      end
   endgenerate
endmodule // pfs_evt_cnt

/* pfs_evt_src.sv */
module pfs_evt_src (
   input logic i_clk,
   input logic i_en,
   output logic [25:0] o_ev = 26'h0,
   output logic [15:0] o_len = 16'h0,
   output logic [15:0] o_len2 = 16'h0,
   output logic [15:0] o_max = 16'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 67;
   logic [15:0] edg[8] = '{16'h3f, 16'h40, 16'h41, 16'h7f, 16'h80, 16'h5ee, 16'h5ef, 16'h5f2};
   // half the lengths sit on a bin edge, random ones rarely would
   always @(posedge i_clk) begin
      o_ev <= i_en ? 26'($random(seed)) : 26'h0;
      o_len <= seed[0] ? edg[seed[3:1]] : 16'h30 + 16'($random(seed) & 'h7ff);
      o_len2 <= 16'($random(seed));
      o_max <= 16'h5d0 + 16'($random(seed) & 'h3f);
   end
endmodule // pfs_evt_src

/* pfs_port_stats.v */
`include "pfs_defs.vh"
// Overview of operation
// - count pause frames, never in half duplex
// - transmit length histogram, seven bins, bad included
// - octet total of every frame, checksum included
// - transmit errors equal sum of collision counts
// - count 64-1518 frames with checksum error
// - count frames above configured maximum size
// - count frames lost to transmit underrun
// - discard total equals sum of single, multiple and excessive collision counts
// - count frames sent after exactly one collision
// - count frames sent after two+ collisions
// - count frames abandoned for excessive collisions
// - count egress filter drops only when enabled
// - count ingress membership and frame-type drops
// - count local traffic drops
// - count VLAN entry busy or unconfigured drops
// - count multicast tree busy drops
// - count unsupported reserved address drops
// - count CFI non-canonical RIF drops
// - count drops for lack of descriptors
// - count unicast, multicast, broadcast transmit requests
// - processor tx octets with framing, rx without
// - count EAPOL frames per direction
module pfs_port_stats #(
   parameter W = 32,
   parameter OW = 64,
   parameter LW = 16,
   parameter SEC_CYC = `PFS_SEC_CYC
) (
   // clock and reset
   input wire i_core_clk,
   input wire i_sys_rst,
   // software control
   input wire i_clr,
   input wire i_sel_valid,
   input wire [4:0] i_sel,
   // receive events
   input wire i_rx_pause,
   input wire i_half_duplex,
   input wire i_rx_ing_drop,
   input wire i_rx_ftype_drop,
   // forwarding drops
   input wire i_fwd_local,
   input wire i_fwd_vlan,
   input wire i_fwd_mtree,
   input wire i_fwd_rsvd,
   input wire i_fwd_cfi,
   input wire i_fwd_nodesc,
   // transmit frame end
   input wire i_tx_done,
   input wire [LW-1:0] i_tx_len,
   input wire i_tx_fcs_bad,
   input wire i_tx_align_bad,
   input wire [LW-1:0] i_max_len,
   input wire i_tx_underrun,
   input wire [1:0] i_tx_col,
   input wire i_tx_xcol,
   // transmit requests
   input wire i_tx_req,
   input wire [1:0] i_tx_cast,
   input wire i_egr_drop,
   input wire i_egr_filt_en,
   // authenticator
   input wire i_eap_rx,
   input wire i_eap_tx,
   // processor traffic
   input wire i_cpu_rx,
   input wire [LW-1:0] i_cpu_rx_len,
   input wire i_cpu_tx,
   input wire [LW-1:0] i_cpu_tx_len,
   // readout
   output reg [W-1:0] o_rd_data,
   output reg [OW-1:0] o_tx_octets,
   output reg [OW-1:0] o_cpu_rx_octets,
   output reg [OW-1:0] o_cpu_tx_octets,
   output reg [W-1:0] o_tx_err_total,
   output reg [W-1:0] o_tx_disc_total,
   output reg [W-1:0] o_secs_since_clr
);
   // ==========================================
   // framing overhead: preamble, delimiter, gap
   localparam [LW-1:0] FRAMING = 16'h0014;
   localparam [1:0] CAST_UC = 2'h0;
   localparam [1:0] CAST_MC = 2'h1;
   localparam [1:0] CAST_BC = 2'h2;
   localparam [1:0] COL_NONE = 2'h0;
   localparam [1:0] COL_ONE = 2'h1;

   function in_range;
      input [LW-1:0] len;
      input [LW-1:0] lo;
      input [LW-1:0] hi;
      begin
         in_range = (len >= lo) && (len <= hi);
      end
   endfunction

   // ==========================================
   // event decode
   reg [`PFS_NUM_EVT-1:0] inc;
   wire sent_ok;
   assign sent_ok = i_tx_done && !i_tx_underrun && !i_tx_xcol;
   always @* begin
      inc = {`PFS_NUM_EVT{1'b0}};
      inc[`PFS_C_PAUSE] = i_rx_pause && !i_half_duplex;
      inc[`PFS_C_H64] = i_tx_done && (i_tx_len == `PFS_LEN_MIN);
      inc[`PFS_C_H127] = i_tx_done && in_range(i_tx_len, 16'h0041, `PFS_LEN_127);
      inc[`PFS_C_H255] = i_tx_done && in_range(i_tx_len, 16'h0080, `PFS_LEN_255);
      inc[`PFS_C_H511] = i_tx_done && in_range(i_tx_len, 16'h0100, `PFS_LEN_511);
      inc[`PFS_C_H1023] = i_tx_done && in_range(i_tx_len, 16'h0200, `PFS_LEN_1023);
      inc[`PFS_C_H1518] = i_tx_done && in_range(i_tx_len, 16'h0400, `PFS_LEN_1518);
      inc[`PFS_C_H1522] = i_tx_done && in_range(i_tx_len, 16'h05ef, `PFS_LEN_1522);
      // alignment errors are not checksum errors
      inc[`PFS_C_FCS] = i_tx_done && i_tx_fcs_bad && !i_tx_align_bad
                        && in_range(i_tx_len, `PFS_LEN_MIN, `PFS_LEN_1518);
      inc[`PFS_C_OVERSZ] = i_tx_done && (i_tx_len > i_max_len);
      inc[`PFS_C_UNDRUN] = i_tx_done && i_tx_underrun;
      inc[`PFS_C_SCOL] = sent_ok && (i_tx_col == COL_ONE);
      inc[`PFS_C_MCOL] = sent_ok && (i_tx_col != COL_NONE) && (i_tx_col != COL_ONE);
      inc[`PFS_C_XCOL] = i_tx_done && i_tx_xcol && !i_tx_underrun;
      inc[`PFS_C_EGRMEM] = i_egr_drop && i_egr_filt_en;
      inc[`PFS_C_INGMEM] = i_rx_ing_drop;
      inc[`PFS_C_FTYPE] = i_rx_ftype_drop;
      inc[`PFS_C_LOCAL] = i_fwd_local;
      inc[`PFS_C_VLANV] = i_fwd_vlan;
      inc[`PFS_C_MTREE] = i_fwd_mtree;
      inc[`PFS_C_RSVD] = i_fwd_rsvd;
      inc[`PFS_C_CFI] = i_fwd_cfi;
      inc[`PFS_C_NODESC] = i_fwd_nodesc;
      inc[`PFS_C_UCAST] = i_tx_req && (i_tx_cast == CAST_UC);
      inc[`PFS_C_MCAST] = i_tx_req && (i_tx_cast == CAST_MC);
      inc[`PFS_C_BCAST] = i_tx_req && (i_tx_cast == CAST_BC);
      inc[`PFS_C_EAPRX] = i_eap_rx;
      inc[`PFS_C_EAPTX] = i_eap_tx;
   end

   // ==========================================
   // counter bank
   wire [`PFS_NUM_EVT*W-1:0] cnt;
   pfs_evt_cnt #(
      .N(`PFS_NUM_EVT),
      .W(W)
   ) u_cnt (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_clr(i_clr),
      .i_inc(inc),
      .o_cnt(cnt)
   );

   wire [W-1:0] scol_c;
   wire [W-1:0] mcol_c;
   wire [W-1:0] xcol_c;
   assign scol_c = cnt[`PFS_C_SCOL*W +: W];
   assign mcol_c = cnt[`PFS_C_MCOL*W +: W];
   assign xcol_c = cnt[`PFS_C_XCOL*W +: W];

   // ==========================================
   // readout, octet totals and derived sums
   // tick counter kept at 32 bits so a narrow W still reaches a full second
   localparam [31:0] SEC_LAST = SEC_CYC - 1;
   reg [31:0] sec_cnt_r;
   wire sec_tick;
   assign sec_tick = (sec_cnt_r == SEC_LAST);
   // widen before adding framing so a long length cannot wrap in 16 bits
   wire [OW-1:0] cpu_tx_add;
   assign cpu_tx_add = {{(OW-LW){1'b0}}, i_cpu_tx_len} + {{(OW-LW){1'b0}}, FRAMING};
   wire [W-1:0] col_sum;
   // totals track live counts one cycle behind
   assign col_sum = scol_c + mcol_c + xcol_c;

   always @(posedge i_core_clk) begin
      if (i_sys_rst || i_clr) begin
         o_rd_data <= {W{1'b0}};
         o_tx_octets <= {OW{1'b0}};
         o_cpu_rx_octets <= {OW{1'b0}};
         o_cpu_tx_octets <= {OW{1'b0}};
         o_tx_err_total <= {W{1'b0}};
         o_tx_disc_total <= {W{1'b0}};
         o_secs_since_clr <= {W{1'b0}};
         sec_cnt_r <= 32'h0;
      end else begin
         if (i_sel_valid && (i_sel < `PFS_NUM_EVT)) begin
            o_rd_data <= cnt[i_sel*W +: W];
         end else if (i_sel_valid) begin
            o_rd_data <= {W{1'b0}};
         end
         if (i_tx_done) begin
            o_tx_octets <= o_tx_octets + {{(OW-LW){1'b0}}, i_tx_len};
         end
         if (i_cpu_rx) begin
            o_cpu_rx_octets <= o_cpu_rx_octets + {{(OW-LW){1'b0}}, i_cpu_rx_len};
         end
         if (i_cpu_tx) begin
            o_cpu_tx_octets <= o_cpu_tx_octets + cpu_tx_add;
         end
         o_tx_err_total <= col_sum;
         o_tx_disc_total <= col_sum;
         if (sec_tick) begin
            sec_cnt_r <= 32'h0;
            o_secs_since_clr <= o_secs_since_clr + {{(W-1){1'b0}}, 1'b1};
         end else begin
            sec_cnt_r <= sec_cnt_r + 32'h1;
         end
      end
   end
endmodule // pfs_port_stats

/* pfs_port_stats_tb_top.sv */
module pfs_port_stats_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, clr = 0, sv = 0, en = 0;
   logic [4:0] sel = 5'h0;
   wire [25:0] e;
   wire [15:0] ln, l2, mx;
   wire [7:0] rd, et, dt, ss;
   wire [63:0] to, cr, ct;
   integer mismatches = 0, compares = 0, i, j, r;
   longint x[28], tx, cx, px;
   int lo[7] = '{64, 65, 128, 256, 512, 1024, 1519};
   int hi[7] = '{64, 127, 255, 511, 1023, 1518, 1522};
   always #2 clk = ~clk;
   pfs_evt_src src_u (.i_clk(clk), .i_en(en), .o_ev(e), .o_len(ln), .o_len2(l2), .o_max(mx));
   // counters 8 wide so wrap is reached quickly
   pfs_port_stats #(.W(8), .SEC_CYC(10)) dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_clr(clr),
      .i_sel_valid(sv), .i_sel(sel), .i_rx_pause(e[0]), .i_half_duplex(e[1]),
      .i_rx_ing_drop(e[2]), .i_rx_ftype_drop(e[3]), .i_fwd_local(e[4]), .i_fwd_vlan(e[5]),
      .i_fwd_mtree(e[6]), .i_fwd_rsvd(e[7]), .i_fwd_cfi(e[8]), .i_fwd_nodesc(e[9]),
      .i_tx_done(e[10]), .i_tx_len(ln), .i_tx_fcs_bad(e[11]), .i_tx_align_bad(e[12]),
      .i_max_len(mx), .i_tx_underrun(e[13]), .i_tx_col(e[17:16]), .i_tx_xcol(e[14]),
      .i_tx_req(e[15]), .i_tx_cast(e[19:18]), .i_egr_drop(e[20]), .i_egr_filt_en(e[21]),
      .i_eap_rx(e[22]), .i_eap_tx(e[23]), .i_cpu_rx(e[24]), .i_cpu_rx_len(l2),
      .i_cpu_tx(e[25]), .i_cpu_tx_len(l2), .o_rd_data(rd), .o_tx_octets(to),
      .o_cpu_rx_octets(cr), .o_cpu_tx_octets(ct), .o_tx_err_total(et),
      .o_tx_disc_total(dt), .o_secs_since_clr(ss));
   task chk(input logic [63:0] s, input longint w);
      compares++;
      if (s !== w) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, w);
      end
   endtask
   task test_done;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // reference model, same edge as the design
   always @(posedge clk)
      if (rst || clr) begin
         foreach (x[k]) x[k] = 0;
         tx = 0;
         cx = 0;
         px = 0;
      end else begin
         if (e[0] && !e[1]) x[0]++;
         for (j = 2; j < 10; j++) if (e[j]) x[j + 13]++;
         if (e[10]) begin
            tx += ln;
            for (j = 0; j < 7; j++) if (ln >= lo[j] && ln <= hi[j]) x[j + 1]++;
            if (e[11] && !e[12] && ln >= 64 && ln <= 1518) x[8]++;
            if (ln > mx) x[9]++;
            if (e[13]) x[10]++;
            else if (e[14]) x[13]++;
            else if (e[17:16] != 0) x[e[17:16] == 1 ? 11 : 12]++;
         end
         if (e[15] && e[19:18] != 3) x[23 + e[19:18]]++;
         if (e[20] && e[21]) x[14]++;
         if (e[22]) x[26]++;
         if (e[23]) x[27]++;
         if (e[24]) cx += l2;
         if (e[25]) px += l2 + 20;
      end
   // ==========================================
   // sequence
   initial begin
      #100us;
      mismatches++;
      test_done;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      for (r = 0; r < 2; r++) begin
         en <= 1;
         repeat (700) @(posedge clk);
         clr <= 1;
         @(posedge clk);
         clr <= 0;
         repeat (900) @(posedge clk);
         en <= 0;
         repeat (4) @(posedge clk);
         for (i = 0; i < 29; i++) begin
            sv <= 1;
            sel <= i[4:0];
            @(posedge clk);
            sv <= 0;
            @(posedge clk);
            #1 chk(rd, i < 28 ? x[i] & 255 : 0);
         end
         chk(to, tx);
         chk(cr, cx);
         chk(ct, px);
         chk(et, (x[11] + x[12] + x[13]) & 255);
         chk(dt, (x[11] + x[12] + x[13]) & 255);
      end
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      repeat (25) @(posedge clk);
      #1 chk(ss, 2);
      test_done;
   end
endmodule // pfs_port_stats_tb_top
bind pfs_port_stats pfs_checker #(.W(W), .OW(OW), .LW(LW)) chk_u (.*);
